// >>> rtl/hbridge_drive_ctrl.sv
`timescale 1ns/10ps
module hbridge_drive_ctrl (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic rotation_sense_out,
	output logic short_load_out,
	output logic pulse_out,
	input wire logic overtemp_warn_n,
	output logic irq
);
	import hb_ctrl_pkg::*;

	logic [4:0] ctrl_q;
	logic [15:0] period_q;
	logic [15:0] duty_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_mask_q;
	logic [15:0] cnt_q;
	logic [7:0] gap_q;
	logic dir_q;
	logic brk_q;
	logic pwm_q;
	logic warn_q;
	logic warn_prev_q;
	logic warn_lvl;
	logic aw_hold_q;
	logic w_hold_q;
	logic [7:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic do_write;
	logic wr_hit;
	logic rd_hit;
	logic [31:0] rd_val;
	logic phase_hi;
	logic want_dir;
	logic want_brk;
	logic want_pwm;
	logic warn_rise;
	logic warn_fall;
	mode_t mode;

	// Flag pin is asynchronous, filtered through three stages
	pin_sync3 u_warn_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_in(overtemp_warn_n),
		.level_q(warn_lvl)
	);

	// Write address half, held until the write is done
	assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_q <= 1'b0;
			awaddr_q <= 8'h00;
			s_axi_awready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_hold_q && !s_axi_awready && s_axi_awvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end else if (do_write) begin
				aw_hold_q <= 1'b0;
			end
		end
	end

	// Write data half, taken before or after the address
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_hold_q <= 1'b0;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_wready <= !w_hold_q && !s_axi_wready && s_axi_wvalid;
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end else if (do_write) begin
				w_hold_q <= 1'b0;
			end
		end
	end

	// Status writes are accepted and ignored
	assign wr_hit = (awaddr_q == ADDR_CTRL) || (awaddr_q == ADDR_PERIOD) || (awaddr_q == ADDR_DUTY)
		|| (awaddr_q == ADDR_STATUS) || (awaddr_q == ADDR_IRQ_STAT) || (awaddr_q == ADDR_IRQ_MASK);

	// Write answer once both halves are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Control and timing registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= 5'h00;
			period_q <= PERIOD_RST;
			duty_q <= DUTY_RST;
			irq_mask_q <= 2'h0;
		end else if (do_write) begin
			if (awaddr_q == ADDR_CTRL && wstrb_q[0]) begin
				ctrl_q <= wdata_q[4:0];
			end
			if (awaddr_q == ADDR_PERIOD) begin
				if (wstrb_q[0]) period_q[7:0] <= wdata_q[7:0];
				if (wstrb_q[1]) period_q[15:8] <= wdata_q[15:8];
			end
			if (awaddr_q == ADDR_DUTY) begin
				if (wstrb_q[0]) duty_q[7:0] <= wdata_q[7:0];
				if (wstrb_q[1]) duty_q[15:8] <= wdata_q[15:8];
			end
			if (awaddr_q == ADDR_IRQ_MASK && wstrb_q[0]) begin
				irq_mask_q <= wdata_q[1:0];
			end
		end
	end

	// Flag edges: warning entered and warning left
	// Filtered level idles high, so reset shows no edge
	assign warn_rise = warn_prev_q && !warn_lvl;
	assign warn_fall = !warn_prev_q && warn_lvl;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			warn_prev_q <= 1'b1;
			warn_q <= 1'b0;
		end else begin
			warn_prev_q <= warn_lvl;
			warn_q <= !warn_lvl; // see RULE_15
		end
	end

	// Sticky events, set wins over a write-one clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_q <= 2'h0;
		end else begin
			// Clear first, so a new event wins
			for (int i = 0; i < 2; i++) begin
				if (do_write && awaddr_q == ADDR_IRQ_STAT && wstrb_q[0] && wdata_q[i]) begin
					irq_stat_q[i] <= 1'b0;
				end
			end
			if (warn_rise) irq_stat_q[IRQ_WARN_SET] <= 1'b1; // see RULE_16
			if (warn_fall) irq_stat_q[IRQ_WARN_CLR] <= 1'b1;
		end
	end

	// Level interrupt from unmasked events
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_q & irq_mask_q); // see RULE_16
		end
	end

	// Read channel
	assign rd_hit = (s_axi_araddr == ADDR_CTRL) || (s_axi_araddr == ADDR_PERIOD) || (s_axi_araddr == ADDR_DUTY)
		|| (s_axi_araddr == ADDR_STATUS) || (s_axi_araddr == ADDR_IRQ_STAT) || (s_axi_araddr == ADDR_IRQ_MASK);
	// Unmapped reads return zero
	always_comb begin
		rd_val = 32'h0000_0000;
		unique case (s_axi_araddr)
			ADDR_CTRL: rd_val = {27'h000_0000, ctrl_q};
			ADDR_PERIOD: rd_val = {16'h0000, period_q};
			ADDR_DUTY: rd_val = {16'h0000, duty_q};
			ADDR_STATUS: rd_val = {28'h000_0000, warn_q, pwm_q, brk_q, dir_q};
			ADDR_IRQ_STAT: rd_val = {30'h0000_0000, irq_stat_q};
			ADDR_IRQ_MASK: rd_val = {30'h0000_0000, irq_mask_q};
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// Address taken first, data answered the cycle after
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_rvalid) begin
				if (s_axi_rready) s_axi_rvalid <= 1'b0;
			end else if (s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
			end else if (s_axi_arvalid) begin
				s_axi_arready <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// PWM period counter
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 16'h0000;
		end else if (cnt_q >= period_q) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
		end
	end
	// High part of each period
	assign phase_hi = cnt_q < duty_q;

	// Wanted pin levels from mode and orders
	assign mode = ctrl_q[CTRL_MODE] ? MODE_ANTI_PHASE : MODE_SIGN_MAG;
	always_comb begin
		want_dir = 1'b0;
		want_brk = 1'b1;
		want_pwm = 1'b0;
		if (!ctrl_q[CTRL_EN]) begin
			want_brk = 1'b1; // see RULE_04
			want_pwm = 1'b0;
		end else if (ctrl_q[CTRL_COAST]) begin
			want_brk = 1'b1; // see RULE_04
			want_pwm = 1'b0;
			want_dir = dir_q;
		end else if (ctrl_q[CTRL_BRAKE]) begin
			want_brk = 1'b1; // see RULE_03
			want_pwm = 1'b1; // see RULE_02
			want_dir = ctrl_q[CTRL_SIGN];
		end else begin
			want_brk = 1'b0;
			unique case (mode)
				MODE_ANTI_PHASE: begin
					want_pwm = 1'b1; // see RULE_06
					want_dir = phase_hi; // see RULE_07
				end
				MODE_SIGN_MAG: begin
					want_dir = ctrl_q[CTRL_SIGN]; // see RULE_08
					want_pwm = phase_hi; // see RULE_09
				end
			endcase
		end
	end

	// One pin changes at a time, then a hold-off of GAP_CYC
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dir_q <= 1'b0;
			brk_q <= 1'b1;
			pwm_q <= 1'b0;
			gap_q <= 8'h00;
		end else if (gap_q != 8'h00) begin
			gap_q <= gap_q - 8'h01; // see RULE_10
		end else if (want_brk != brk_q) begin
			brk_q <= want_brk;
			gap_q <= GAP_CYC; // see RULE_11
		end else if (want_pwm != pwm_q) begin
			pwm_q <= want_pwm;
			gap_q <= GAP_CYC; // see RULE_12
		end else if (want_dir != dir_q) begin
			dir_q <= want_dir;
			gap_q <= GAP_CYC; // see RULE_10
		end
	end

	// Pins straight from flops
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rotation_sense_out <= 1'b0;
			short_load_out <= 1'b1;
			pulse_out <= 1'b0;
		end else begin
			rotation_sense_out <= dir_q;
			short_load_out <= brk_q;
			pulse_out <= pwm_q;
		end
	end
endmodule

// >>> rtl/hb_ctrl_pkg.sv
// Notes on behaviour
// RULE_01: Pulse high, no brake: direction picks current.
// RULE_02: Brake with pulse high shorts load.
// RULE_03: Braking requires brake and pulse both high.
// RULE_04: Brake with pulse low turns all off.
// RULE_05: No brake, pulse low: both sourcing on.
// RULE_06: Anti-phase: modulate direction, pulse held high.
// RULE_07: Anti-phase: half duty means zero drive.
// RULE_08: Sign/magnitude: sign on direction, magnitude pulse.
// RULE_09: Magnitude low means zero; width sets current.
// RULE_10: Space edges of any two inputs 1 us.
// RULE_11: Keep 500 ns between transitions.
// RULE_12: Each input pulse lasts at least 1 us.
// RULE_13: Warning flag low at warning temperature.
// RULE_14: Outputs off only at shutdown temperature.
// RULE_15: Flag is open-collector, wire-ORed, pulled up.
// RULE_16: Treat flag as interrupt; reduce or stop. Code only raises irq and never reduces or stops the drive itself.
// RULE_17: Device cuts stage on upper-switch overload.
// RULE_18: Device retries periodically after overload.
// RULE_19: Never both switches of one half-bridge.
package hb_ctrl_pkg;
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned EDGE_GAP_NS = 1000;
	localparam int unsigned MIN_PULSE_NS = 1000;
	localparam int unsigned GAP_NS = (EDGE_GAP_NS > MIN_PULSE_NS) ? EDGE_GAP_NS : MIN_PULSE_NS;
	localparam int unsigned GAP_CYC_I = (GAP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [7:0] GAP_CYC = 8'(GAP_CYC_I);
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PERIOD = 8'h04;
	localparam logic [7:0] ADDR_DUTY = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
	localparam int unsigned CTRL_EN = 0;
	localparam int unsigned CTRL_MODE = 1;
	localparam int unsigned CTRL_SIGN = 2;
	localparam int unsigned CTRL_BRAKE = 3;
	localparam int unsigned CTRL_COAST = 4;
	localparam int unsigned IRQ_WARN_SET = 0;
	localparam int unsigned IRQ_WARN_CLR = 1;
	localparam logic [15:0] PERIOD_RST = 16'h03E8;
	localparam logic [15:0] DUTY_RST = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {
		MODE_SIGN_MAG = 2'b00,
		MODE_ANTI_PHASE = 2'b01
	} mode_t;
endpackage

// >>> rtl/pin_sync3.sv
`timescale 1ns/10ps
module pin_sync3 (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic pin_in,
	output logic level_q
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			level_q <= 1'b1;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				level_q <= s3_q;
			end
		end
	end
endmodule

// >>> verification/bridge_model.sv
`timescale 1ns/10ps
module bridge_model (
	input wire logic dir,
	input wire logic brk,
	input wire logic pwm,
	input wire logic warm,
	input wire logic trip,
	output logic [3:0] sw,
	output logic flag_n
);
	// Switches {src1,snk1,src2,snk2}
	always_comb begin
		if (trip) sw = 4'h0;
		else if (!pwm) sw = brk ? 4'h0 : 4'hA;
		else if (brk) sw = dir ? 4'hA : 4'h5;
		else sw = dir ? 4'h9 : 4'h6;
	end
	assign flag_n = !warm;
endmodule

// >>> verification/hbridge_drive_ctrl_props.sv
`timescale 1ns/10ps
module hbridge_drive_ctrl_chk
	import hb_ctrl_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rotation_sense_out,
	input wire logic short_load_out,
	input wire logic pulse_out
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [2:0] pins;
	logic [7:0] gap_q;
	assign pins = {rotation_sense_out, short_load_out, pulse_out};
	always_ff @(posedge aclk) begin
		if (!aresetn) gap_q <= 8'hFF;
		else if ($changed(pins)) gap_q <= 8'h00;
		else if (gap_q != 8'hFF) gap_q <= gap_q + 8'h01;
	end
	a_one_pin_step: assert property ($countones(pins ^ $past(pins)) <= 1)
		else $error("two pins moved together");
	a_edge_gap: assert property ($changed(pins) |-> gap_q >= GAP_CYC - 8'h01)
		else $error("pin edges too close");
	a_pulse_width: assert property ($changed(pulse_out) |=> $stable(pulse_out) [*8])
		else $error("pulse too short");
	a_reset_off: assert property (disable iff (1'b0) !aresetn |=> short_load_out && !pulse_out)
		else $error("bridge not off in reset");
	a_read_answer: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
		|=> s_axi_arready && !s_axi_rvalid ##1 s_axi_rvalid)
		else $error("read not answered");
	a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("rvalid held");
	a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("bvalid held");
	a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("awready held");
endmodule
bind hbridge_drive_ctrl hbridge_drive_ctrl_chk u_hbridge_drive_ctrl_chk (.*);

// >>> verification/tb.sv
`timescale 1ns/10ps
module tb;
	import hb_ctrl_pkg::*;
	localparam logic [31:0] EN = 32'h1 << CTRL_EN, MD = 32'h1 << CTRL_MODE, SG = 32'h1 << CTRL_SIGN;
	localparam logic [31:0] BK = 32'h1 << CTRL_BRAKE, CO = 32'h1 << CTRL_COAST;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic rotation_sense_out, short_load_out, pulse_out, overtemp_warn_n, irq, warm, trip;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb, sw;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	int n_errors, compares, hp, hd;
	hbridge_drive_ctrl u_hbridge_drive_ctrl (.*);
	bridge_model u_bridge_model (.dir(rotation_sense_out), .brk(short_load_out), .pwm(pulse_out), .warm(warm),
		.trip(trip), .sw(sw), .flag_n(overtemp_warn_n));
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw;
		logic w;
		aw = 1'b0;
		w = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			aw = aw | s_axi_awready;
			w = w | s_axi_wready;
			s_axi_awvalid <= !aw;
			s_axi_wvalid <= !w;
		end
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic ctl(input logic [31:0] c);
		wr(ADDR_CTRL, c);
		repeat (100) @(posedge aclk);
	endtask
	task automatic meas;
		hp = 0;
		hd = 0;
		repeat (400) begin
			@(posedge aclk);
			hp += pulse_out;
			hd += rotation_sense_out;
		end
	endtask
	task automatic t_regs;
		rd(ADDR_PERIOD);
		chk(d, {16'h0000, PERIOD_RST});
		chk(r, RESP_OKAY);
		rd(ADDR_STATUS);
		chk(d, 32'h0000_0002);
		rd(8'h20);
		chk(r, RESP_SLVERR);
		wr(8'h20, 32'h0000_0001);
		chk(r, RESP_SLVERR);
		$display("regs done");
	endtask
	task automatic t_signmag;
		wr(ADDR_PERIOD, 32'h0000_0063);
		ctl(EN | SG);
		chk(sw, 4'hA);
		wr(ADDR_DUTY, 32'h0000_0064);
		ctl(EN | SG);
		chk(sw, 4'h9);
		ctl(EN);
		chk(sw, 4'h6);
		wr(ADDR_DUTY, 32'h0000_0028);
		meas();
		chk(hp >= 140 && hp <= 180, 1'h1);
		wr(ADDR_DUTY, 32'h0000_0005);
		meas();
		chk(hp >= 80 && hp <= 100, 1'h1);
		$display("sign-magnitude done");
	endtask
	task automatic t_brake;
		ctl(EN | BK | SG);
		chk(sw, 4'hA);
		trip <= 1'b1;
		repeat (2) @(posedge aclk);
		chk(sw, 4'h0);
		trip <= 1'b0;
		repeat (2) @(posedge aclk);
		chk(sw, 4'hA);
		ctl(EN | BK);
		chk(sw, 4'h5);
		ctl(EN | CO);
		chk(sw, 4'h0);
		ctl(32'h0000_0000);
		chk(sw, 4'h0);
		$display("brake done");
	endtask
	task automatic t_anti;
		wr(ADDR_DUTY, 32'h0000_0032);
		ctl(EN | MD);
		meas();
		chk(hp, 400);
		chk(hd >= 180 && hd <= 220, 1'h1);
		$display("anti-phase done");
	endtask
	task automatic t_flag;
		wr(ADDR_IRQ_MASK, 32'h0000_0003);
		chk(r, RESP_OKAY);
		warm <= 1'b1;
		repeat (20) @(posedge aclk);
		chk(irq, 1'h1);
		rd(ADDR_STATUS);
		chk(d[3], 1'h1);
		wr(ADDR_IRQ_STAT, 32'h0000_0001);
		repeat (2) @(posedge aclk);
		chk(irq, 1'h0);
		warm <= 1'b0;
		repeat (20) @(posedge aclk);
		chk(irq, 1'h1);
		wr(ADDR_IRQ_MASK, 32'h0000_0000);
		repeat (2) @(posedge aclk);
		chk(irq, 1'h0);
		wr(ADDR_IRQ_STAT, 32'h0000_0003);
		rd(ADDR_IRQ_STAT);
		chk(d, 32'h0000_0000);
		$display("flag done");
	endtask
	task automatic summarize;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		n_errors++;
		summarize();
	end
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, warm, trip} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		n_errors = 0;
		compares = 0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_signmag();
		t_brake();
		t_anti();
		t_flag();
		summarize();
	end
endmodule
